//--- rtl/gdf_pkg.sv
// constants for the gate driver fault logic
// assumes one 125 MHz system clock and synchronous active-low reset
package gdf_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    // typical blanking time; the real value follows the blanking resistor
    localparam int BLANK_TIME_NS = 100;
    // least time, rounded up to whole cycles
    localparam int BLANK_CYCLES = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_CNT_W = 8;

    // ---------------------------------------------------------------
    // values after reset
    // ---------------------------------------------------------------
    localparam logic GATE_RESET = 1'b0;
    // flag high after reset: gate drive power not yet known good
    localparam logic FLAG_RESET = 1'b1;
    localparam logic PIN_RESET = 1'b0;
    localparam logic SUPPLY_LOW_RESET = 1'b1;

endpackage : gdf_pkg

//--- rtl/pin_sync.sv
// three-stage synchroniser for one asynchronous pin
// assumes the pin is a plain digital level; output moves once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input logic clk_sys_i,
    input logic rst_n_i,
    input logic pin_i,
    output logic level_o
);

    logic s1;
    logic s2;
    logic s3;
    logic next_level;

    always_comb begin
        next_level = level_o;
        if (s2 == s3) begin
            next_level = s3;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
            level_o <= RESET_VAL;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            level_o <= next_level;
        end
    end

endmodule : pin_sync

//--- rtl/blank_timer.sv
// blanking interval timer, restarted by a one-cycle start pulse
// assumes start comes from logic on the same clock
`timescale 1ns/1ns
module blank_timer #(
    parameter int CYC = 13,
    parameter int CW = 8
) (
    input logic clk_sys_i,
    input logic rst_n_i,
    input logic start_i,
    output logic blanking_o
);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;

    always_comb begin
        next_count = count;
        if (start_i) begin
            next_count = CW'(CYC - 1);
        end else if (count != '0) begin
            next_count = count - CW'(1);
        end
    end

    // blanking covers the start cycle plus CYC-1 following cycles
    assign blanking_o = start_i | (count != '0);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule : blank_timer

//--- rtl/gate_fault_logic.sv
// fault detection, fault flag and gate inhibit of a synchronous buck gate driver
// assumes analog comparators outside deliver digital levels; dead time lives elsewhere
//
// What this block does
// - high-side on, switch below reference raises fault
// - blank the high-side comparator after switching
// - blanking restarts on each switch-node rising edge
// - monitor above limit flags output over-current
// - hold monitor value during blanking, no flag
// - flag low normally, high on any fault
// - flag covers exactly four fault types
// - clear flag at clean PWM pulse falling edge
// - short pulses may need several clearing pulses
// - thermal shutdown forces both gates low
// - thermal shutdown sets flag, exit clears it
// - supply lockout holds both gates low, auto release
// - supply lockout drives flag, including power-up
// - over-current faults raise flag, drop both gates
// - high-side fault retries each PWM pulse
// - both faults together: no new high pulse
// - output over-current only clears when current drops
`timescale 1ns/1ns
module gate_fault_logic import gdf_pkg::*; #(
    parameter int BLANK_CYC = BLANK_CYCLES
) (
    input logic clk_sys_i,
    input logic rst_n_i,
    input logic pwm_in_i,
    input logic rectifier_enable_in_i,
    input logic switch_node_i,
    input logic high_side_sense_ref_trip_i,
    input logic oc_trip_i,
    input logic supply_low_i,
    input logic over_temp_i,
    output logic high_side_gate_out_o,
    output logic low_side_gate_out_o,
    output logic fault_flag_out_o
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic pwm;
    logic rectifier_enable_in;
    logic sw;
    logic hs_cmp;
    logic oc_cmp;
    logic supply_low;
    logic hot;

    pin_sync #(.RESET_VAL(PIN_RESET)) u_sync_pwm (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(pwm_in_i),
        .level_o(pwm)
    );
    pin_sync #(.RESET_VAL(PIN_RESET)) u_sync_sre (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(rectifier_enable_in_i),
        .level_o(rectifier_enable_in)
    );
    pin_sync #(.RESET_VAL(PIN_RESET)) u_sync_sw (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(switch_node_i),
        .level_o(sw)
    );
    pin_sync #(.RESET_VAL(PIN_RESET)) u_sync_hs (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(high_side_sense_ref_trip_i),
        .level_o(hs_cmp)
    );
    pin_sync #(.RESET_VAL(PIN_RESET)) u_sync_oc (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(oc_trip_i),
        .level_o(oc_cmp)
    );
    pin_sync #(.RESET_VAL(SUPPLY_LOW_RESET)) u_sync_uvlo (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(supply_low_i),
        .level_o(supply_low)
    );
    pin_sync #(.RESET_VAL(PIN_RESET)) u_sync_hot (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(over_temp_i),
        .level_o(hot)
    );

    // ---------------------------------------------------------------
    // edges and blanking
    // ---------------------------------------------------------------
    logic pwm_d;
    logic sw_d;
    logic pwm_rise;
    logic pwm_fall;
    logic sw_rise;
    logic blanking;

    assign pwm_rise = pwm & ~pwm_d;
    assign pwm_fall = ~pwm & pwm_d;
    assign sw_rise = sw & ~sw_d;

    blank_timer #(.CYC(BLANK_CYC), .CW(BLANK_CNT_W)) u_blank (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .start_i(sw_rise),
        .blanking_o(blanking)
    );

    // ---------------------------------------------------------------
    // fault state
    // ---------------------------------------------------------------
    logic oc_held;
    logic hs_trip;
    logic seen;
    logic flag_oc;
    logic hs_event;
    logic inhibit;
    logic next_pwm_d;
    logic next_sw_d;
    logic next_oc_held;
    logic next_hs_trip;
    logic next_seen;
    logic next_flag_oc;
    logic next_high_side_gate_out;
    logic next_low_side_gate_out;
    logic next_flag;

    // high-side compare only while the gate is on and outside blanking
    assign hs_event = high_side_gate_out_o & sw & hs_cmp & ~blanking;

    always_comb begin
        next_pwm_d = pwm;
        next_sw_d = sw;
        // monitor value frozen while blanking
        next_oc_held = blanking ? oc_held : oc_cmp;
        // cleared at a new pulse only if output current is already gone
        next_hs_trip = hs_event | (hs_trip & ~(pwm_rise & ~oc_held));
        // a high-side or output over-current fault during the on-time blocks the next clear
        next_seen = (pwm_rise ? 1'b0 : seen) | (pwm & (hs_event | oc_held));
        // set wins over clear; clear only at a clean falling edge
        next_flag_oc = hs_event | oc_held | (flag_oc & ~(pwm_fall & ~seen));
        inhibit = hot | supply_low | oc_held | next_hs_trip;
        next_high_side_gate_out = pwm & ~inhibit;
        next_low_side_gate_out = ~pwm & rectifier_enable_in & ~inhibit;
        next_flag = next_flag_oc | supply_low | hot;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pwm_d <= PIN_RESET;
            sw_d <= PIN_RESET;
            oc_held <= PIN_RESET;
            hs_trip <= PIN_RESET;
            seen <= PIN_RESET;
            flag_oc <= PIN_RESET;
            high_side_gate_out_o <= GATE_RESET;
            low_side_gate_out_o <= GATE_RESET;
            fault_flag_out_o <= FLAG_RESET;
        end else begin
            pwm_d <= next_pwm_d;
            sw_d <= next_sw_d;
            oc_held <= next_oc_held;
            hs_trip <= next_hs_trip;
            seen <= next_seen;
            flag_oc <= next_flag_oc;
            high_side_gate_out_o <= next_high_side_gate_out;
            low_side_gate_out_o <= next_low_side_gate_out;
            fault_flag_out_o <= next_flag;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence clean_fall_s;
        pwm_fall && !seen && !hs_event && !oc_held && !supply_low && !hot;
    endsequence

    sequence retry_s;
        hs_trip && pwm_rise && !oc_held && !hot && !supply_low && !hs_event;
    endsequence

    chk_hot_gates_off: assert property (hot |=> !high_side_gate_out_o && !low_side_gate_out_o)
        else $error("gate driven during thermal shutdown");
    chk_uvlo_gates_off: assert property (supply_low |=> !high_side_gate_out_o && !low_side_gate_out_o)
        else $error("gate driven during supply lockout");
    chk_uvlo_flag: assert property (supply_low |=> fault_flag_out_o)
        else $error("flag low during supply lockout");
    chk_hot_flag: assert property (hot |=> fault_flag_out_o)
        else $error("flag low during thermal shutdown");
    chk_hs_trip_off: assert property (hs_event |=> fault_flag_out_o && !high_side_gate_out_o
        && !low_side_gate_out_o)
        else $error("high-side fault did not drop gates and raise flag");
    chk_blank_masks: assert property (blanking |-> !hs_event)
        else $error("high-side fault seen during blanking");
    chk_blank_start: assert property (sw_rise |-> blanking ##1 blanking)
        else $error("blanking not started on switch edge");
    chk_oc_hold: assert property (blanking |=> oc_held == $past(oc_held))
        else $error("monitor value moved during blanking");
    chk_oc_sample: assert property (oc_cmp && !blanking |=> oc_held ##1 fault_flag_out_o)
        else $error("output over-current not flagged");
    chk_flag_clear: assert property (clean_fall_s |=> !fault_flag_out_o)
        else $error("flag not cleared at clean falling edge");
    chk_flag_stays: assert property (flag_oc && pwm_fall && seen |=> fault_flag_out_o)
        else $error("flag cleared after faulted pulse");
    chk_oc_no_pulse: assert property (oc_held |=> !high_side_gate_out_o)
        else $error("high-side pulse issued under output over-current");
    chk_retry_pulse: assert property (retry_s ##0 pwm |=> high_side_gate_out_o)
        else $error("no new high-side pulse after high-side fault");

endmodule : gate_fault_logic

//--- sim/pwm_host_model.sv
// controller model: drives pwm, mirrors the switch node, reads the fault flag
// assumes the driver's gate outputs change on clk_sys_i
`timescale 1ns/1ns
module pwm_host_model (
    input wire logic clk_sys_i,
    input wire logic high_side_gate_i,
    input wire logic fault_flag_i,
    output logic pwm_o,
    output logic switch_node_o
);
    initial pwm_o = 1'b0;
    initial switch_node_o = 1'b0;

    // switch node rises one cycle after the high-side gate turns on
    always @(posedge clk_sys_i) switch_node_o <= #1 high_side_gate_i;

    task automatic pulse(input int on_c, input int off_c);
        @(posedge clk_sys_i);
        #1 pwm_o = 1'b1;
        repeat (on_c) @(posedge clk_sys_i);
        #1 pwm_o = 1'b0;
        repeat (off_c) @(posedge clk_sys_i);
        #1;
    endtask : pulse

    // conversion starts only once the flag reads low
    task automatic wait_power_good(output bit ok);
        ok = 1'b0;
        repeat (64) begin
            @(posedge clk_sys_i);
            if (fault_flag_i === 1'b0) ok = 1'b1;
        end
        #1;
    endtask : wait_power_good
endmodule : pwm_host_model

//--- sim/gate_fault_logic_test.sv
// self-checking bench for the gate driver fault logic
// assumes pins settle about five clocks after a change; blanking shortened to 4
`timescale 1ns/1ns
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module gate_fault_logic_test;
    import gdf_pkg::*;
    logic clk_sys_i, rst_n_i, pwm, rect_en, sw_node, hs_trip, oc_trip, supply_low, over_temp;
    logic high_side_gate_out, low_side_gate_out, flag;
    int fail_count = 0;
    int compares = 0;
    int hs_seen = 0;
    bit ok;

    gate_fault_logic #(.BLANK_CYC(4)) gate_fault_logic_inst (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .pwm_in_i(pwm),
        .rectifier_enable_in_i(rect_en), .switch_node_i(sw_node), .high_side_sense_ref_trip_i(hs_trip),
        .oc_trip_i(oc_trip), .supply_low_i(supply_low), .over_temp_i(over_temp),
        .high_side_gate_out_o(high_side_gate_out), .low_side_gate_out_o(low_side_gate_out), .fault_flag_out_o(flag));
    pwm_host_model pwm_host_model_inst (
        .clk_sys_i(clk_sys_i), .high_side_gate_i(high_side_gate_out), .fault_flag_i(flag),
        .pwm_o(pwm), .switch_node_o(sw_node));

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) if (high_side_gate_out === 1'b1) hs_seen <= hs_seen + 1;

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : step
    task automatic pulse(input int on_c);
        hs_seen = 0;
        pwm_host_model_inst.pulse(on_c, 20);
    endtask : pulse

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic power_up;
        `CHECK(flag, 1'b1)
        `CHECK(high_side_gate_out | low_side_gate_out, 1'b0)
        supply_low = 1'b0;
        pwm_host_model_inst.wait_power_good(ok);
        `CHECK(ok, 1'b1)
        `CHECK(flag, 1'b0)
    endtask : power_up

    task automatic high_side_fault;
        hs_trip = 1'b1;
        pulse(2);
        `CHECK(flag, 1'b0)
        for (int i = 0; i < 2; i++) begin
            pulse(30);
            `CHECK(hs_seen > 0 && hs_seen < 25, 1'b1)
            `CHECK(flag, 1'b1)
        end
        `CHECK(low_side_gate_out, 1'b0)
        hs_trip = 1'b0;
        pulse(30);
        `CHECK(hs_seen > 24, 1'b1)
        `CHECK(flag, 1'b0)
        `CHECK(low_side_gate_out, 1'b1)
    endtask : high_side_fault

    task automatic output_oc_fault;
        oc_trip = 1'b1;
        hs_trip = 1'b1;
        step(10);
        `CHECK(flag, 1'b1)
        pulse(30);
        `CHECK(hs_seen, 0)
        `CHECK(low_side_gate_out, 1'b0)
        oc_trip = 1'b0;
        hs_trip = 1'b0;
        step(10);
        `CHECK(flag, 1'b1)
        pulse(30);
        `CHECK(hs_seen > 24, 1'b1)
        `CHECK(flag, 1'b0)
    endtask : output_oc_fault

    task automatic level_faults;
        for (int i = 0; i < 2; i++) begin
            if (i == 0) over_temp = 1'b1;
            else supply_low = 1'b1;
            step(10);
            `CHECK(flag, 1'b1)
            pulse(20);
            `CHECK(hs_seen, 0)
            `CHECK(low_side_gate_out, 1'b0)
            over_temp = 1'b0;
            supply_low = 1'b0;
            step(10);
            `CHECK(flag, 1'b0)
            pulse(20);
            `CHECK(hs_seen > 14, 1'b1)
        end
    endtask : level_faults

    task automatic tally_and_finish;
        if (fail_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        rst_n_i = 1'b0;
        rect_en = 1'b1;
        hs_trip = 1'b0;
        oc_trip = 1'b0;
        supply_low = 1'b1;
        over_temp = 1'b0;
        step(16);
        rst_n_i = 1'b1;
        step(2);
        power_up();
        high_side_fault();
        output_oc_fault();
        level_faults();
        tally_and_finish();
    end

    // whole run is well under 1000 cycles
    initial begin
        #40000;
        fail_count++;
        tally_and_finish();
    end
endmodule : gate_fault_logic_test
